/* File: rtl/ibc_defines.svh */
// offsets, field positions, response codes and reset values for the
// interleaved block i/o channel; included by the rtl and the bench
`ifndef IBC_DEFINES_SVH
`define IBC_DEFINES_SVH
`define IBC_ADDR_CTRL     12'h000
`define IBC_ADDR_ADDRW    12'h004
`define IBC_ADDR_CMD      12'h008
`define IBC_ADDR_STATUS   12'h00C
`define IBC_ADDR_PTR0     12'h010
`define IBC_ADDR_PTR1     12'h014
`define IBC_ADDR_CNT0     12'h018
`define IBC_ADDR_CNT1     12'h01C
`define IBC_ADDR_CMDW     12'h020
`define IBC_BIT_BLOCK     23
`define IBC_BIT_OUTDIR    22
`define IBC_BIT_REINIT    23
`define IBC_RESP_OKAY     2'h0
`define IBC_RESP_SLVERR   2'h2
`define IBC_ZERO_WORD     24'h000000
`endif

/* File: rtl/ibc_pkg.sv */
// types for the interleaved block i/o channel
// assumes ibc_defines.svh on the include path
package ibc_pkg;
  typedef enum logic [2:0] {
    IBC_IDLE, IBC_MEM, IBC_FETCH_CNT, IBC_FETCH_ADR, IBC_FETCH_NXT
  } ibc_state_t;
  typedef struct packed {
    logic [23:0] ptr;
    logic [23:0] cnt;
    logic        reinit;
    logic        armed;
  } ibc_unit_t;
endpackage

/* File: rtl/ibc_channel.sv */
// interleaved block i/o channel: two unit parameter sets, memory master,
// axi4-lite register slave
// assumes a memory port that holds grant one cycle per word and unit
// lines arriving asynchronously (they are synchronised here)
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "ibc_defines.svh"

module ibc_channel #(
  parameter int UNITS = 2,
  parameter int AW    = 24
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [UNITS-1:0]  unit_req,
  input  wire logic [UNITS-1:0]  unit_input,
  input  wire logic [UNITS-1:0]  unit_block_mode,
  input  wire logic [UNITS-1:0]  unit_addr_here,
  input  wire logic [23:0]       unit_data_in,
  output logic [23:0]            unit_data_out,
  output logic [UNITS-1:0]       unit_data_strobe,
  output logic [UNITS-1:0]       unit_count_done,
  output logic [UNITS-1:0]       unit_command_strobe,
  output logic [23:0]            unit_command,
  output logic                   mem_req,
  input  wire logic              mem_grant,
  output logic                   mem_we,
  output logic [AW-1:0]          mem_addr,
  output logic [23:0]            mem_wdata,
  input  wire logic [23:0]       mem_rdata
);
  // ----------------------------------------------------------------
  // unit line synchronisers
  // ----------------------------------------------------------------
  logic [4*UNITS-1:0] sync1_r, sync2_r;
  logic [23:0]        din1_r, din2_r;
  always_ff @(posedge aclk) begin
    sync1_r <= {unit_req, unit_input, unit_block_mode, unit_addr_here};
    sync2_r <= sync1_r;
    din1_r  <= unit_data_in;
    din2_r  <= din1_r;
  end
  wire logic [UNITS-1:0] req_s  = sync2_r[4*UNITS-1:3*UNITS];
  wire logic [UNITS-1:0] inp_s  = sync2_r[3*UNITS-1:2*UNITS];
  wire logic [UNITS-1:0] blk_s  = sync2_r[2*UNITS-1:UNITS];
  wire logic [UNITS-1:0] ahr_s  = sync2_r[UNITS-1:0];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ibc_pkg::ibc_state_t state_r;
  ibc_pkg::ibc_unit_t  par_r [UNITS];
  logic [23:0]         addrw_r, cmdw_r;
  logic                cur_r, dir_in_r, step_r;
  logic [23:0]         word_r;
  logic [23:0]         fetch_adr_r;
  logic [UNITS-1:0]    req_seen_r;
  logic [UNITS-1:0]    sel_r;

  // lowest unit number wins
  function automatic logic pick(input logic [UNITS-1:0] v);
    return v[0] ? 1'b0 : 1'b1;
  endfunction

  // a request is served once per assertion; edge kept on second flop
  wire logic [UNITS-1:0] req_new = req_s & ~req_seen_r;
  wire logic [UNITS-1:0] elig;
  genvar g;
  for (g = 0; g < UNITS; g++) begin : g_elig
    assign elig[g] = req_new[g] &
      (par_r[g].armed | ~blk_s[g] | (ahr_s[g] & inp_s[g]));
  end
  wire logic         idle     = (state_r == ibc_pkg::IBC_IDLE);
  wire logic         busy     = ~idle;
  wire logic         any_req  = idle & (|elig);
  wire logic         win      = pick(elig);
  wire logic         ext_load = ahr_s[win] & inp_s[win];
  wire logic         granted  = mem_req & mem_grant;
  wire ibc_pkg::ibc_unit_t cp = par_r[cur_r];
  wire logic         last     = step_r & (cp.cnt == 24'h000001);

  // ----------------------------------------------------------------
  // axi4-lite slave: one write and one read outstanding
  // ----------------------------------------------------------------
  logic        aw_hold_r, w_hold_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
  wire logic [11:0] wa = aw_hold_r ? awaddr_r : s_axi_awaddr;
  wire logic [31:0] wd = w_hold_r ? wdata_r : s_axi_wdata;
  wire logic have_aw = aw_hold_r | s_axi_awvalid;
  wire logic have_w  = w_hold_r | s_axi_wvalid;
  wire logic wr_go   = have_aw & have_w & ~s_axi_bvalid;
  wire logic wr_lane = &s_axi_wstrb[2:0] | w_hold_r;
  wire logic wr_addrw = wr_go & wa == `IBC_ADDR_ADDRW;
  // command refused while busy; software polls status and retries
  wire logic wr_cmd  = wr_go & wa == `IBC_ADDR_CMD & idle;
  wire logic wr_ok   = (wa == `IBC_ADDR_ADDRW) |
                       (wa == `IBC_ADDR_CTRL) |
                       ((wa == `IBC_ADDR_CMD) & idle);
  wire logic [UNITS-1:0] cmd_unit = wd[24] ? 2'b10 : 2'b01;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      awaddr_r     <= 12'h000;
      wdata_r      <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `IBC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready & ~wr_go) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready & ~wr_go) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `IBC_RESP_OKAY : `IBC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  wire logic unused_lane = wr_lane;

  assign s_axi_arready = ~s_axi_rvalid;
  wire logic [11:0] ra = s_axi_araddr;
  wire logic rd_ptr = (ra == `IBC_ADDR_PTR0) | (ra == `IBC_ADDR_PTR1);
  wire logic rd_cnt = (ra == `IBC_ADDR_CNT0) | (ra == `IBC_ADDR_CNT1);
  wire logic rd_refuse = (rd_ptr | rd_cnt) & busy;
  wire logic [31:0] rd_val;
  assign rd_val =
    (ra == `IBC_ADDR_STATUS) ? {28'h0000000, par_r[1].armed,
                                par_r[0].armed, 1'b0, busy} :
    (ra == `IBC_ADDR_ADDRW)  ? {8'h00, addrw_r} :
    (ra == `IBC_ADDR_CMDW)   ? {8'h00, cmdw_r} :
    (ra == `IBC_ADDR_PTR0)   ? {8'h00, par_r[0].ptr} :
    (ra == `IBC_ADDR_PTR1)   ? {8'h00, par_r[1].ptr} :
    (ra == `IBC_ADDR_CNT0)   ? {8'h00, par_r[0].cnt} :
    (ra == `IBC_ADDR_CNT1)   ? {8'h00, par_r[1].cnt} : 32'h00000000;
  wire logic rd_map = (ra == `IBC_ADDR_STATUS) | (ra == `IBC_ADDR_ADDRW) |
                      (ra == `IBC_ADDR_CMDW) | rd_ptr | rd_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `IBC_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_refuse ? 32'h00000000 : rd_val;
      s_axi_rresp  <= (rd_map & ~rd_refuse) ? `IBC_RESP_OKAY
                                            : `IBC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r             <= ibc_pkg::IBC_IDLE;
      for (int i = 0; i < UNITS; i++) par_r[i] <= '0;
      addrw_r             <= `IBC_ZERO_WORD;
      cmdw_r              <= `IBC_ZERO_WORD;
      cur_r               <= 1'b0;
      dir_in_r            <= 1'b0;
      step_r              <= 1'b0;
      word_r              <= `IBC_ZERO_WORD;
      fetch_adr_r         <= `IBC_ZERO_WORD;
      req_seen_r          <= '0;
      sel_r               <= '0;
      mem_req             <= 1'b0;
      mem_we              <= 1'b0;
      mem_addr            <= '0;
      mem_wdata           <= `IBC_ZERO_WORD;
      unit_data_out       <= `IBC_ZERO_WORD;
      unit_data_strobe    <= '0;
      unit_count_done     <= '0;
      unit_command_strobe <= '0;
      unit_command        <= `IBC_ZERO_WORD;
    end else begin
      unit_data_strobe    <= '0;
      unit_count_done     <= '0;
      unit_command_strobe <= '0;
      req_seen_r          <= req_seen_r & req_s;
      if (wr_addrw) addrw_r <= wd[23:0];
      if (wr_cmd) begin
        // parameter pair fetched from the address word first
        cmdw_r              <= wd[23:0];
        unit_command        <= wd[23:0];
        unit_command_strobe <= cmd_unit;
        cur_r               <= wd[24];
        sel_r               <= cmd_unit;
        fetch_adr_r         <= addrw_r;
        mem_req             <= 1'b1;
        mem_we              <= 1'b0;
        mem_addr            <= addrw_r[AW-1:0];
        state_r             <= ibc_pkg::IBC_FETCH_CNT;
      end else begin
        case (state_r)
          ibc_pkg::IBC_IDLE: begin
            if (any_req) begin
              req_seen_r[win] <= 1'b1;
              cur_r           <= win;
              if (ext_load) begin
                par_r[win].ptr <= din2_r;
              end else begin
                dir_in_r  <= inp_s[win];
                step_r    <= blk_s[win] & par_r[win].armed;
                mem_req   <= 1'b1;
                mem_we    <= inp_s[win];
                mem_addr  <= par_r[win].ptr[AW-1:0];
                mem_wdata <= din2_r;
                state_r   <= ibc_pkg::IBC_MEM;
              end
            end
          end
          ibc_pkg::IBC_MEM: begin
            if (granted) begin
              mem_req <= 1'b0;
              mem_we  <= 1'b0;
              if (!dir_in_r) begin
                // output word goes out with a strobe only, no reply
                unit_data_out           <= mem_rdata;
                unit_data_strobe[cur_r] <= 1'b1;
              end
              if (step_r) begin
                par_r[cur_r].ptr <= cp.ptr + 24'h000001;
                par_r[cur_r].cnt <= cp.cnt - 24'h000001;
              end
              if (last) begin
                unit_count_done[cur_r] <= 1'b1;
                if (cp.reinit) begin
                  // word after the buffer holds next parameter address
                  fetch_adr_r <= cp.ptr + 24'h000001;
                  mem_req     <= 1'b1;
                  mem_addr    <= 24'(cp.ptr + 24'h000001);
                  state_r     <= ibc_pkg::IBC_FETCH_NXT;
                end else begin
                  par_r[cur_r].armed <= 1'b0;
                  state_r            <= ibc_pkg::IBC_IDLE;
                end
              end else begin
                state_r <= ibc_pkg::IBC_IDLE;
              end
            end
          end
          ibc_pkg::IBC_FETCH_NXT: begin
            if (granted) begin
              fetch_adr_r <= mem_rdata;
              mem_addr    <= mem_rdata[AW-1:0];
              state_r     <= ibc_pkg::IBC_FETCH_CNT;
            end
          end
          ibc_pkg::IBC_FETCH_CNT: begin
            if (granted) begin
              par_r[cur_r].cnt <= mem_rdata;
              mem_addr         <= 24'(fetch_adr_r + 24'h000001);
              state_r          <= ibc_pkg::IBC_FETCH_ADR;
            end
          end
          ibc_pkg::IBC_FETCH_ADR: begin
            if (granted) begin
              par_r[cur_r].ptr   <= {1'b0, mem_rdata[22:0]};
              par_r[cur_r].reinit <= mem_rdata[`IBC_BIT_REINIT];
              par_r[cur_r].armed <= 1'b1;
              mem_req            <= 1'b0;
              state_r            <= ibc_pkg::IBC_IDLE;
            end
          end
          default: state_r <= ibc_pkg::IBC_IDLE;
        endcase
      end
    end
  end
  wire logic [UNITS-1:0] unused_sel = sel_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_REQ_HELD: assert property (@(posedge aclk) disable iff (!aresetn)
    mem_req & ~mem_grant & state_r == ibc_pkg::IBC_MEM |=>
      mem_req & $stable(mem_addr))
    else $error("memory request dropped before grant");
  AST_NOT_BUSY: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ibc_pkg::IBC_MEM & granted & ~last |=>
      state_r == ibc_pkg::IBC_IDLE)
    else $error("channel stays busy after a transfer");
  AST_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ibc_pkg::IBC_MEM & granted & step_r & ~wr_cmd |=>
      par_r[cur_r].cnt == $past(cp.cnt) - 24'h000001)
    else $error("count not decremented");
  AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ibc_pkg::IBC_MEM & granted & ~step_r & ~last & ~wr_cmd |=>
      par_r[cur_r].ptr == $past(cp.ptr))
    else $error("pointer moved outside block mode");
  AST_DONE: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ibc_pkg::IBC_MEM & granted & last & ~wr_cmd |=>
      unit_count_done == (2'b01 << $past(cur_r)))
    else $error("count complete missing or to wrong unit");
  AST_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ibc_pkg::IBC_MEM & granted & ~dir_in_r & ~wr_cmd |=>
      unit_data_out == $past(mem_rdata) & |unit_data_strobe)
    else $error("output word not delivered");
  AST_PRIO: assert property (@(posedge aclk) disable iff (!aresetn)
    any_req & elig[0] & ~wr_cmd |=> cur_r == 1'b0)
    else $error("lower priority unit served first");
  AST_EXT: assert property (@(posedge aclk) disable iff (!aresetn)
    any_req & ext_load & ~wr_cmd |=>
      cur_r == $past(win) & par_r[cur_r].ptr == $past(din2_r))
    else $error("external address not loaded");
  AST_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
    any_req & ~ext_load & ~wr_cmd |=>
      mem_addr == $past(par_r[win].ptr[AW-1:0]) & mem_req)
    else $error("memory address not from stored pointer");
  AST_REFUSE: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid & s_axi_arready & rd_ptr & busy |=>
      s_axi_rresp == `IBC_RESP_SLVERR)
    else $error("readback accepted while busy");
endmodule // ibc_channel
`default_nettype wire

/* File: bench/ibc_unit_model.sv */
// partner model: the two unit controllers on the channel's unit lines
// assumes the bench runs one transfer per unit at a time
`timescale 1ns/1ns
`default_nettype none
module ibc_unit_model (
  input  wire logic        aclk,
  output logic [1:0]       unit_req,
  output logic [1:0]       unit_input,
  output logic [1:0]       unit_block_mode,
  output logic [1:0]       unit_addr_here,
  output logic [23:0]      unit_data_in,
  input  wire logic [1:0]  unit_data_strobe,
  input  wire logic        mem_req,
  input  wire logic        mem_grant,
  input  wire logic        mem_we
);
  initial begin
    unit_req        = 2'h0;
    unit_input      = 2'h0;
    unit_block_mode = 2'h0;
    unit_addr_here  = 2'h0;
    unit_data_in    = 24'hFFFFFF;
  end
  // ---------------------------------------------------------------
  // one transfer; without ans the line is held a fixed time
  // ---------------------------------------------------------------
  task automatic xfer(input int u, input logic inp, input logic blk,
                      input logic ah, input logic [23:0] d,
                      input bit ans);
    int n;
    @(posedge aclk);
    unit_input[u]      <= inp;
    unit_block_mode[u] <= blk;
    unit_addr_here[u]  <= ah;
    if (inp) unit_data_in <= d;
    repeat (3) @(posedge aclk);
    unit_req[u] <= 1'b1;
    n = 0;
    // output words are never acknowledged: the strobe ends it
    do begin
      @(posedge aclk);
      n++;
    end while (ans ? !(inp ? (mem_req && mem_grant && mem_we)
                           : unit_data_strobe[u]) : n < 12);
    unit_req[u] <= 1'b0;
    // a released data bus must not look like the last word
    if (inp) unit_data_in <= ~d;
    repeat (3) @(posedge aclk);
  endtask
endmodule // ibc_unit_model
`default_nettype wire

/* File: bench/ibc_channel_tb.sv */
// self-checking bench: axi4-lite tasks, memory responder, unit model
// assumes ibc_defines.svh on the include path
`timescale 1ns/1ns
`default_nettype none
`include "ibc_defines.svh"
module ibc_channel_tb;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, req, inp, blk, ah, dstb, done, cstb, last_cs;
  logic [23:0] din, dout, cmd, maddr, mwdata, mrdata, last_out, last_cmd;
  logic        mreq, mwe;
  logic        mgnt = 1'b0;
  logic [23:0] mem [0:255];
  int          mismatches = 0, cmp_count = 0, gnt_dly = 0;
  int          cycles = 0, wcnt = 0;
  int          dones [2] = '{0, 0};
  int          order_q [$];
  ibc_channel i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .unit_req(req), .unit_input(inp),
    .unit_block_mode(blk), .unit_addr_here(ah), .unit_data_in(din),
    .unit_data_out(dout), .unit_data_strobe(dstb),
    .unit_count_done(done), .unit_command_strobe(cstb),
    .unit_command(cmd), .mem_req(mreq), .mem_grant(mgnt), .mem_we(mwe),
    .mem_addr(maddr), .mem_wdata(mwdata), .mem_rdata(mrdata));
  ibc_unit_model i_unit (.aclk(aclk), .unit_req(req), .unit_input(inp),
    .unit_block_mode(blk), .unit_addr_here(ah), .unit_data_in(din),
    .unit_data_strobe(dstb), .mem_req(mreq), .mem_grant(mgnt),
    .mem_we(mwe));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // ---------------------------------------------------------------
  // memory responder and monitors
  // ---------------------------------------------------------------
  // outside a grant the read bus carries the inverted addressed word
  assign mrdata = mgnt ? mem[maddr[7:0]] : ~mem[maddr[7:0]];
  // a hang ends here as a counted mismatch
  always @(posedge aclk) begin
    if (cycles > 20000) begin
      err("timeout");
      wrap_up();
    end
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    mgnt <= 1'b0;
    if (mreq && !mgnt) begin
      mgnt <= (wcnt >= gnt_dly);
      wcnt <= (wcnt >= gnt_dly) ? 0 : wcnt + 1;
    end else if (!mreq && wcnt > 0) begin
      err("memory request dropped before grant");
      wcnt <= 0;
    end
    if (mreq && mgnt && mwe) mem[maddr[7:0]] <= mwdata;
    for (int u = 0; u < 2; u++) begin
      if (done[u]) dones[u]++;
      if (dstb[u]) order_q.push_back(u);
    end
    if (|dstb) last_out <= dout;
    if (|cstb) begin
      last_cmd <= cmd;
      last_cs <= cstb;
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic err(input string m);
    $display("ERROR %0t: %s", $time, m);
    mismatches++;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    cmp_count++;
    if (g !== e) err(m);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(bresp, er, "write response");
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(r, er, "read response");
    chk(d, ed, "read data");
  endtask
  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0]  r;
    do axi_rd(`IBC_ADDR_STATUS, d, r); while (d[0] !== 1'b0);
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 56'h00000000000000;
    foreach (mem[i]) mem[i] = 24'h000000;
    mem[8'h10] = 24'h000002;
    mem[8'h11] = 24'h000040;
    mem[8'h42] = 24'h111111;
    mem[8'h20] = 24'h000001;
    mem[8'h21] = 24'h800060;
    mem[8'h60] = 24'hD1D1D1;
    mem[8'h61] = 24'h000030;
    mem[8'h30] = 24'h000001;
    mem[8'h31] = 24'h000070;
    mem[8'h70] = 24'hD2D2D2;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd_chk(`IBC_ADDR_STATUS, 32'h0, `IBC_RESP_OKAY);
    axi_wr(12'h100, 32'h0, `IBC_RESP_SLVERR);
    axi_wr(`IBC_ADDR_ADDRW, 32'h10, `IBC_RESP_OKAY);
    axi_wr(`IBC_ADDR_CMD, 32'h00800000, `IBC_RESP_OKAY);
    wait_idle();
    chk({last_cs, last_cmd}, {2'b01, 24'h800000}, "command");
    rd_chk(`IBC_ADDR_PTR0, 32'h40, `IBC_RESP_OKAY);
    rd_chk(`IBC_ADDR_CNT0, 32'h2, `IBC_RESP_OKAY);
    rd_chk(`IBC_ADDR_STATUS, 32'h4, `IBC_RESP_OKAY);
    rd_chk(`IBC_ADDR_CMDW, 32'h800000, `IBC_RESP_OKAY);
    rd_chk(`IBC_ADDR_ADDRW, 32'h10, `IBC_RESP_OKAY);
    i_unit.xfer(0, 1'b1, 1'b1, 1'b0, 24'hA5A5A5, 1'b1);
    i_unit.xfer(0, 1'b1, 1'b1, 1'b0, 24'h5A5A5A, 1'b1);
    chk(mem[8'h40], 24'hA5A5A5, "first input word");
    chk(mem[8'h41], 24'h5A5A5A, "second input word");
    rd_chk(`IBC_ADDR_PTR0, 32'h42, `IBC_RESP_OKAY);
    rd_chk(`IBC_ADDR_CNT0, 32'h0, `IBC_RESP_OKAY);
    chk(dones[0] + 2 * dones[1], 1, "count done");
    i_unit.xfer(0, 1'b1, 1'b1, 1'b0, 24'h777777, 1'b0);
    chk(mem[8'h42], 24'h111111, "exhausted unit served");
    rd_chk(`IBC_ADDR_STATUS, 32'h0, `IBC_RESP_OKAY);
    gnt_dly = 15;
    fork
      i_unit.xfer(0, 1'b1, 1'b0, 1'b0, 24'h333333, 1'b1);
      begin
        while (!mreq) @(posedge aclk);
        rd_chk(`IBC_ADDR_PTR0, 32'h0, `IBC_RESP_SLVERR);
        axi_wr(`IBC_ADDR_CMD, 32'h00800000, `IBC_RESP_SLVERR);
      end
    join
    gnt_dly = 0;
    chk(mem[8'h42], 24'h333333, "input word");
    rd_chk(`IBC_ADDR_PTR0, 32'h42, `IBC_RESP_OKAY);
    i_unit.xfer(1, 1'b1, 1'b0, 1'b1, 24'h000050, 1'b0);
    rd_chk(`IBC_ADDR_PTR1, 32'h50, `IBC_RESP_OKAY);
    i_unit.xfer(1, 1'b1, 1'b0, 1'b0, 24'h0ABCDE, 1'b1);
    chk(mem[8'h50], 24'h0ABCDE, "external address write");
    i_unit.xfer(1, 1'b0, 1'b0, 1'b0, 24'h0, 1'b1);
    chk(last_out, 24'h0ABCDE, "register word read");
    rd_chk(`IBC_ADDR_PTR1, 32'h50, `IBC_RESP_OKAY);
    order_q.delete();
    fork
      i_unit.xfer(0, 1'b0, 1'b0, 1'b0, 24'h0, 1'b1);
      i_unit.xfer(1, 1'b0, 1'b0, 1'b0, 24'h0, 1'b1);
    join
    chk(order_q.size(), 2, "strobe count");
    chk(order_q[0], 0, "priority order");
    axi_wr(`IBC_ADDR_ADDRW, 32'h20, `IBC_RESP_OKAY);
    axi_wr(`IBC_ADDR_CMD, 32'h01C00000, `IBC_RESP_OKAY);
    wait_idle();
    chk({last_cs, last_cmd}, {2'b10, 24'hC00000}, "command");
    rd_chk(`IBC_ADDR_PTR1, 32'h60, `IBC_RESP_OKAY);
    rd_chk(`IBC_ADDR_STATUS, 32'h8, `IBC_RESP_OKAY);
    i_unit.xfer(1, 1'b0, 1'b1, 1'b0, 24'h0, 1'b1);
    chk(last_out, 24'hD1D1D1, "first buffer word");
    wait_idle();
    rd_chk(`IBC_ADDR_PTR1, 32'h70, `IBC_RESP_OKAY);
    rd_chk(`IBC_ADDR_CNT1, 32'h1, `IBC_RESP_OKAY);
    i_unit.xfer(1, 1'b0, 1'b1, 1'b0, 24'h0, 1'b1);
    chk(last_out, 24'hD2D2D2, "second buffer word");
    chk(dones[1], 2, "unit one count done");
    wrap_up();
  end
endmodule // ibc_channel_tb
`default_nettype wire
